// ### logic/mcu_bus_pin_interface.sv
module mcu_bus_pin_interface (
    input  wire logic                         mclk,                   // System clock, 20 MHz.
    input  wire logic                         arst_n,                 // Asynchronous reset, active low.
    input  wire logic [mcu_port_pkg::BYTE_W-1:0] low_byte_bus_port_in,   // Low port pin level.
    output logic      [mcu_port_pkg::BYTE_W-1:0] low_byte_bus_port_out,  // Low port drive value.
    output logic                              low_byte_bus_port_oe,   // Low port drive enable.
    input  wire logic [mcu_port_pkg::BYTE_W-1:0] high_byte_bus_port_in,  // High port pin level.
    output logic      [mcu_port_pkg::BYTE_W-1:0] high_byte_bus_port_out, // High port drive value.
    output logic                              high_byte_bus_port_oe,  // High port drive enable.
    input  wire logic                         addr_hold_strobe,       // Address latch strobe, active high.
    input  wire logic                         control_input_zero,     // Write strobe or direction pin.
    input  wire logic                         control_input_one,      // Read, E clock, data strobe or fetch.
    input  wire logic                         control_input_two,      // Fetch select or generic input.
    input  wire logic                         reset_pin_n,            // Reset pin, active low.
    input  wire mcu_port_pkg::bus_mode_type   bus_mode,               // Host bus arrangement.
    input  wire mcu_port_pkg::zero_style_type zero_style,             // Meaning of control input zero.
    input  wire mcu_port_pkg::one_style_type  one_style,              // Meaning of control input one.
    input  wire logic                         two_is_fetch,           // Control input two is a fetch select.
    input  wire logic                         block_select,           // An internal block is selected.
    input  wire logic [2*mcu_port_pkg::BYTE_W-1:0] read_data,         // Data from the selected block.
    input  wire logic                         flash_busy,             // Flash program or erase running.
    output mcu_port_pkg::plc_feed_type        plc_feed,               // Address and controls for decoding.
    output logic                              write_pulse,            // One-cycle pulse at end of a write.
    output logic      [2*mcu_port_pkg::BYTE_W-1:0] write_data,        // Data captured for the write.
    output logic                              device_reset,           // Reset to ports and macrocells.
    output logic                              program_abort           // One-cycle flash abort pulse.
);

    import mcu_port_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    pin_sample_type raw_pins;
    pin_sample_type pins;

    assign raw_pins = '{rst_n: reset_pin_n, ctl2: control_input_two, ctl1: control_input_one,
                        ctl0: control_input_zero, strobe: addr_hold_strobe,
                        high: high_byte_bus_port_in, low: low_byte_bus_port_in};

    pin_sync #(
        .WIDTH ($bits(pin_sample_type)),
        .INIT  (PIN_IDLE)
    ) u_pin_sync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .pin    (raw_pins),
        .synced (pins)
    );

    // ------------------------------------------------------------------
    // Control decoding
    // ------------------------------------------------------------------
    logic data_phase;
    logic read_act;
    logic write_act;
    logic reset_act;

    always_comb begin
        data_phase = (one_style == ONE_E_CLOCK) ? pins.ctl1 : !pins.ctl1;
        unique case (one_style)
            ONE_RD_N:    read_act = !pins.ctl1;
            ONE_FETCH_N: read_act = !pins.ctl1;
            ONE_DS_N:    read_act = !pins.ctl1 && pins.ctl0;
            ONE_E_CLOCK: read_act = pins.ctl1 && pins.ctl0;
        endcase
        if (two_is_fetch && !pins.ctl2) begin
            read_act = 1'b1;
        end
        unique case (zero_style)
            ZERO_WR_N: write_act = !pins.ctl0;
            ZERO_RW:   write_act = !pins.ctl0 && data_phase;
        endcase
        reset_act = !pins.rst_n;
    end

    // ------------------------------------------------------------------
    // Address latch
    // ------------------------------------------------------------------
    logic [BYTE_W-1:0] low_latch;
    logic [BYTE_W-1:0] high_latch;
    logic [BYTE_W-1:0] next_low_latch;
    logic [BYTE_W-1:0] next_high_latch;

    always_comb begin
        next_low_latch  = low_latch;
        next_high_latch = high_latch;
        if (pins.strobe) begin
            next_low_latch  = pins.low;
            next_high_latch = pins.high;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            low_latch  <= BYTE_ZERO;
            high_latch <= BYTE_ZERO;
        end else begin
            low_latch  <= next_low_latch;
            high_latch <= next_high_latch;
        end
    end

    // ------------------------------------------------------------------
    // Feed to the programmable logic
    // ------------------------------------------------------------------
    plc_feed_type next_plc_feed;

    always_comb begin
        next_plc_feed        = FEED_IDLE;
        next_plc_feed.ctl0   = pins.ctl0;
        next_plc_feed.ctl1   = pins.ctl1;
        next_plc_feed.ctl2   = pins.ctl2;
        next_plc_feed.strobe = pins.strobe;
        next_plc_feed.read   = read_act;
        next_plc_feed.write  = write_act;
        unique case (bus_mode)
            BUS_MUX:    next_plc_feed.addr = {NIBBLE_ZERO, pins.high, next_low_latch};
            BUS_NONMUX: next_plc_feed.addr = {NIBBLE_ZERO, pins.high, pins.low};
            BUS_PAGE:   next_plc_feed.addr = {NIBBLE_ZERO, next_high_latch, next_low_latch};
            BUS_BURST:  next_plc_feed.addr = {pins.high, next_low_latch, NIBBLE_ZERO};
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            plc_feed <= FEED_IDLE;
        end else begin
            plc_feed <= next_plc_feed;
        end
    end

    // ------------------------------------------------------------------
    // Read data drive
    // ------------------------------------------------------------------
    logic              next_low_oe;
    logic              next_high_oe;
    logic [BYTE_W-1:0] next_low_out;
    logic [BYTE_W-1:0] next_high_out;

    always_comb begin
        next_low_oe   = read_act && block_select && !reset_act;
        next_high_oe  = next_low_oe && (bus_mode == BUS_PAGE);
        next_low_out  = read_data[BYTE_W-1:0];
        next_high_out = read_data[2*BYTE_W-1:BYTE_W];
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            low_byte_bus_port_oe   <= 1'b0;
            high_byte_bus_port_oe  <= 1'b0;
            low_byte_bus_port_out  <= BYTE_ZERO;
            high_byte_bus_port_out <= BYTE_ZERO;
        end else begin
            low_byte_bus_port_oe   <= next_low_oe;
            high_byte_bus_port_oe  <= next_high_oe;
            low_byte_bus_port_out  <= next_low_out;
            high_byte_bus_port_out <= next_high_out;
        end
    end

    // ------------------------------------------------------------------
    // Write capture
    // ------------------------------------------------------------------
    // Data is taken on the last cycle of the strobe, when the host's bus has settled longest.
    logic                  write_seen;
    logic                  next_write_seen;
    logic                  next_write_pulse;
    logic [2*BYTE_W-1:0]   write_hold;
    logic [2*BYTE_W-1:0]   next_write_hold;
    logic [2*BYTE_W-1:0]   next_write_data;

    always_comb begin
        next_write_seen  = write_act && !reset_act;
        next_write_pulse = write_seen && !write_act && !reset_act;
        next_write_hold  = write_hold;
        next_write_data  = write_data;
        if (write_act) begin
            next_write_hold = (bus_mode == BUS_PAGE) ? {pins.high, pins.low} : {BYTE_ZERO, pins.low};
        end
        if (next_write_pulse) begin
            next_write_data = write_hold;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            write_seen  <= 1'b0;
            write_pulse <= 1'b0;
            write_hold  <= {BYTE_ZERO, BYTE_ZERO};
            write_data  <= {BYTE_ZERO, BYTE_ZERO};
        end else begin
            write_seen  <= next_write_seen;
            write_pulse <= next_write_pulse;
            write_hold  <= next_write_hold;
            write_data  <= next_write_data;
        end
    end

    // ------------------------------------------------------------------
    // Reset pin handling
    // ------------------------------------------------------------------
    logic next_device_reset;
    logic next_program_abort;

    always_comb begin
        next_device_reset  = reset_act;
        next_program_abort = reset_act && !device_reset && flash_busy;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            device_reset  <= 1'b1;
            program_abort <= 1'b0;
        end else begin
            device_reset  <= next_device_reset;
            program_abort <= next_program_abort;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    latch_capture_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        pins.strobe |=> (low_latch == $past(pins.low)) && (high_latch == $past(pins.high)))
        else $error("address not captured while strobe asserted");

    latch_hold_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !pins.strobe ##1 !pins.strobe |-> $stable(low_latch) && $stable(high_latch))
        else $error("latched address changed without strobe");

    drive_gate_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        low_byte_bus_port_oe |-> $past(read_act) && $past(block_select) && !$past(reset_act))
        else $error("port driven without read and select");

    drive_on_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (one_style == ONE_RD_N) && !two_is_fetch && !pins.ctl1 && block_select && pins.rst_n
        |=> low_byte_bus_port_oe && (low_byte_bus_port_out == $past(read_data[BYTE_W-1:0])))
        else $error("selected read not driven");

    high_page_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        high_byte_bus_port_oe |-> ($past(bus_mode) == BUS_PAGE) && low_byte_bus_port_oe)
        else $error("high port driven outside page mode");

    burst_addr_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (bus_mode == BUS_BURST) && pins.strobe
        |=> (plc_feed.addr[BURST_LSB-1:0] == NIBBLE_ZERO)
            && (plc_feed.addr[ADDR_W-1:ADDR_W-BYTE_W] == $past(pins.high))
            && (plc_feed.addr[BURST_LSB+BYTE_W-1:BURST_LSB] == $past(pins.low)))
        else $error("burst address mapping wrong");

    nonmux_addr_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (bus_mode == BUS_NONMUX) |=> plc_feed.addr[BYTE_W-1:0] == $past(pins.low))
        else $error("non-multiplexed low address not live");

    high_addr_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        (bus_mode == BUS_MUX) || (bus_mode == BUS_NONMUX)
        |=> plc_feed.addr[2*BYTE_W-1:BYTE_W] == $past(pins.high))
        else $error("high address byte not forwarded");

    control_feed_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        ##1 (plc_feed.ctl0 == $past(pins.ctl0)) && (plc_feed.ctl1 == $past(pins.ctl1))
            && (plc_feed.ctl2 == $past(pins.ctl2)))
        else $error("control inputs not forwarded");

    write_end_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        write_pulse |-> $past(write_act, 2) && !$past(write_act) && (write_data == $past(write_hold)))
        else $error("write pulse without finished strobe");

    reset_ports_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        device_reset |-> !low_byte_bus_port_oe && !high_byte_bus_port_oe && !write_pulse)
        else $error("ports active during reset");

    reset_abort_a: assert property (
        @(posedge mclk) disable iff (!arst_n)
        reset_act && !device_reset && flash_busy |=> program_abort ##1 !program_abort)
        else $error("flash cycle not aborted on reset");

endmodule

// ### logic/mcu_port_pkg.sv
package mcu_port_pkg;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int BYTE_W    = 8;
    localparam int ADDR_W    = 20;
    localparam int BURST_LSB = 4;
    localparam int NIBBLE_W  = 4;

    // ------------------------------------------------------------------
    // Host bus arrangements and control-input styles
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_MUX,
        BUS_NONMUX,
        BUS_PAGE,
        BUS_BURST
    } bus_mode_type;

    typedef enum logic {
        ZERO_WR_N,
        ZERO_RW
    } zero_style_type;

    typedef enum logic [1:0] {
        ONE_RD_N,
        ONE_E_CLOCK,
        ONE_DS_N,
        ONE_FETCH_N
    } one_style_type;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              rst_n;
        logic              ctl2;
        logic              ctl1;
        logic              ctl0;
        logic              strobe;
        logic [BYTE_W-1:0] high;
        logic [BYTE_W-1:0] low;
    } pin_sample_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              ctl0;
        logic              ctl1;
        logic              ctl2;
        logic              strobe;
        logic              read;
        logic              write;
    } plc_feed_type;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam pin_sample_type PIN_IDLE = '{rst_n: 1'b1, ctl2: 1'b1, ctl1: 1'b1, ctl0: 1'b1,
                                            strobe: 1'b0, high: 8'h00, low: 8'h00};
    localparam plc_feed_type   FEED_IDLE = '{addr: 20'h00000, ctl0: 1'b1, ctl1: 1'b1, ctl2: 1'b1,
                                             strobe: 1'b0, read: 1'b0, write: 1'b0};
    localparam logic [BYTE_W-1:0]   BYTE_ZERO   = 8'h00;
    localparam logic [NIBBLE_W-1:0] NIBBLE_ZERO = 4'h0;

endpackage

// ### logic/pin_sync.sv
// ----------------------------------------------------------------------
// Two-stage synchroniser for a vector of pins.
// ----------------------------------------------------------------------
module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             mclk,   // System clock.
    input  wire logic             arst_n, // Asynchronous reset, active low.
    input  wire logic [WIDTH-1:0] pin,    // Raw pin levels.
    output logic      [WIDTH-1:0] synced  // Levels after two flops.
);

    logic [WIDTH-1:0] stage;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stage  <= INIT;
            synced <= INIT;
        end else begin
            stage  <= pin;
            synced <= stage;
        end
    end

endmodule

// ### testbench/host_bus_model.sv
// ----------------------------------------------------------------------
// Host side of the address/data pins, with wire resolution.
// ----------------------------------------------------------------------
module host_bus_model
    import mcu_port_pkg::*;
(
    input  wire logic         mclk,        // Clock for the release pattern.
    input  wire bus_mode_type mode,        // Host bus arrangement.
    input  wire logic [19:0]  host_addr,   // Address the host presents.
    input  wire logic [15:0]  host_data,   // Write data the host presents.
    input  wire logic         addr_phase,  // Host drives the address.
    input  wire logic         data_en,     // Host drives write data.
    input  wire logic [7:0]   dev_low,     // Device low drive value.
    input  wire logic         dev_low_oe,  // Device low drive enable.
    input  wire logic [7:0]   dev_high,    // Device high drive value.
    input  wire logic         dev_high_oe, // Device high drive enable.
    output logic      [7:0]   low_pin,     // Resolved low port level.
    output logic      [7:0]   high_pin     // Resolved high port level.
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] host_low;
    logic [7:0] host_high;
    logic [7:0] last_low  = 8'h00;
    logic [7:0] last_high = 8'h00;
    logic       low_drv;
    logic       high_drv;

    // Released lines show the inverse of the last level so nothing stale passes.
    always_comb begin
        low_drv   = addr_phase || data_en || mode == BUS_NONMUX;
        host_low  = (mode == BUS_BURST) ? host_addr[11:4] : host_addr[7:0];
        if (!addr_phase && mode != BUS_NONMUX) begin
            host_low = host_data[7:0];
        end
        high_drv  = mode != BUS_PAGE || addr_phase || data_en;
        host_high = (mode == BUS_BURST) ? host_addr[19:12] : host_addr[15:8];
        if (mode == BUS_PAGE && !addr_phase) begin
            host_high = host_data[15:8];
        end
    end

    always_ff @(posedge mclk) begin
        last_low  <= low_pin;
        last_high <= high_pin;
    end

    assign low_pin  = dev_low_oe ? dev_low : (low_drv ? host_low : ~last_low);
    assign high_pin = dev_high_oe ? dev_high : (high_drv ? host_high : ~last_high);
endmodule

// ### testbench/mcu_bus_pin_interface_tb_top.sv
module mcu_bus_pin_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mcu_port_pkg::*;

    logic mclk = 1'b0;
    logic arst_n, strobe, ctl0, ctl1, ctl2, reset_pin_n, two_is_fetch, block_select, flash_busy;
    logic addr_phase, data_en, low_oe, high_oe, write_pulse, device_reset, program_abort;
    logic [7:0]  low_in, low_out, high_in, high_out;
    logic [15:0] read_data, host_data, write_data;
    logic [19:0] host_addr, a;
    bus_mode_type   mode;
    zero_style_type zero_style;
    one_style_type  one_style;
    plc_feed_type   plc_feed;
    logic [16:0] rd_q[$];
    logic [15:0] wr_q[$];
    logic [16:0] e;
    logic        prev_oe = 1'b0;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          abort_cnt = 0;
    int          seed = 99;

    always #25 mclk = ~mclk;

    mcu_bus_pin_interface u_mcu_bus_pin_interface (
        .mclk(mclk), .arst_n(arst_n), .low_byte_bus_port_in(low_in), .low_byte_bus_port_out(low_out),
        .low_byte_bus_port_oe(low_oe), .high_byte_bus_port_in(high_in), .high_byte_bus_port_out(high_out),
        .high_byte_bus_port_oe(high_oe), .addr_hold_strobe(strobe), .control_input_zero(ctl0),
        .control_input_one(ctl1), .control_input_two(ctl2), .reset_pin_n(reset_pin_n), .bus_mode(mode),
        .zero_style(zero_style), .one_style(one_style), .two_is_fetch(two_is_fetch),
        .block_select(block_select), .read_data(read_data), .flash_busy(flash_busy), .plc_feed(plc_feed),
        .write_pulse(write_pulse), .write_data(write_data), .device_reset(device_reset),
        .program_abort(program_abort));

    host_bus_model u_host_bus_model (
        .mclk(mclk), .mode(mode), .host_addr(host_addr), .host_data(host_data), .addr_phase(addr_phase),
        .data_en(data_en), .dev_low(low_out), .dev_low_oe(low_oe), .dev_high(high_out),
        .dev_high_oe(high_oe), .low_pin(low_in), .high_pin(high_in));

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask

    task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic idle1();
        return one_style != ONE_E_CLOCK;
    endfunction

    task automatic latch_addr(input logic [19:0] adr);
        host_addr  = adr;
        addr_phase = 1'b1;
        strobe     = 1'b1;
        step(4);
        strobe = 1'b0;
        step(1);
        addr_phase = 1'b0;
        step(5);
        check(plc_feed.addr, (mode == BUS_BURST) ? {adr[19:4], 4'h0} : {4'h0, adr[15:0]}, "addr");
    endtask

    task automatic host_read(input logic sel, input logic via_two);
        read_data    = 16'($random(seed));
        block_select = sel;
        if (sel) rd_q.push_back({mode == BUS_PAGE, read_data});
        if (via_two) ctl2 = 1'b0;
        else ctl1 = (one_style == ONE_E_CLOCK);
        step(5);
        check(20'(plc_feed.read), 20'h1, "read flag");
        if (via_two) check(20'(plc_feed.ctl2), 20'h0, "ctl2");
        ctl1 = idle1();
        ctl2 = 1'b1;
        step(4);
        block_select = 1'b0;
        check(20'(low_oe), 20'h0, "oe off");
    endtask

    task automatic host_write;
        host_data = 16'($random(seed));
        data_en   = 1'b1;
        wr_q.push_back(mode == BUS_PAGE ? host_data : {8'h00, host_data[7:0]});
        ctl0 = 1'b0;
        if (zero_style == ZERO_RW) ctl1 = (one_style == ONE_E_CLOCK);
        step(4);
        check(20'(plc_feed.write), 20'h1, "write flag");
        ctl0 = 1'b1;
        ctl1 = idle1();
        step(1);
        data_en = 1'b0;
        step(4);
    endtask

    // ------------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        #1;
        if (program_abort === 1'b1) abort_cnt++;
        if (low_oe === 1'b1 && prev_oe !== 1'b1) begin
            if (rd_q.size() == 0) begin
                check(20'(low_oe), 20'h0, "unexpected drive");
            end else begin
                e = rd_q.pop_front();
                check(20'(low_out), 20'(e[7:0]), "read low");
                if (e[16]) check({11'h0, high_oe, high_out}, {12'h1, e[15:8]}, "read high");
            end
        end
        prev_oe = low_oe;
        if (write_pulse === 1'b1) begin
            if (wr_q.size() == 0) check(20'(write_pulse), 20'h0, "unexpected write");
            else check(20'(write_data), 20'(wr_q.pop_front()), "write data");
        end
    end

    initial begin
        #(50 * 4000);
        error_cnt++;
        $display("mismatch at %0t: run did not finish", $time);
        results();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        reset_pin_n = 1'b0;
        {strobe, ctl0, ctl1, ctl2} = 4'b0111;
        {two_is_fetch, block_select, flash_busy, addr_phase, data_en} = 5'b00000;
        {read_data, host_data, host_addr} = '0;
        mode = BUS_MUX;
        zero_style = ZERO_WR_N;
        one_style = ONE_FETCH_N;
        repeat (8) @(posedge mclk);
        #5;
        arst_n = 1'b1;
        reset_pin_n = 1'b1;
        step(5);
        check(20'(device_reset), 20'h0, "reset out");
        for (int m = 0; m < 4; m++) begin
            mode       = bus_mode_type'(m);
            zero_style = (m < 2) ? ZERO_WR_N : ZERO_RW;
            one_style  = (m == 0) ? ONE_FETCH_N : (m == 1) ? ONE_RD_N : (m == 2) ? ONE_DS_N : ONE_E_CLOCK;
            ctl1 = idle1();
            a = 20'($random(seed));
            latch_addr(a);
            if (mode != BUS_NONMUX) begin
                host_read(1'b1, 1'b0);
                host_read(1'b0, 1'b0);
                host_write();
                host_read(1'b1, 1'b0);
            end
        end
        one_style = ONE_RD_N;
        ctl1 = 1'b1;
        step(4);
        host_read(1'b1, 1'b0);
        two_is_fetch = 1'b1;
        host_read(1'b1, 1'b1);
        // A selected read held through the reset must never reach the pins.
        flash_busy = 1'b1;
        block_select = 1'b1;
        ctl1 = 1'b0;
        reset_pin_n = 1'b0;
        step(8);
        check(20'(device_reset), 20'h1, "reset on");
        check(20'(low_oe), 20'h0, "oe in reset");
        check(20'(abort_cnt), 20'h1, "abort pulses");
        reset_pin_n = 1'b1;
        ctl1 = 1'b1;
        block_select = 1'b0;
        flash_busy = 1'b0;
        step(5);
        check(20'(device_reset), 20'h0, "reset off");
        check(20'(rd_q.size() + wr_q.size()), 20'h0, "pending results");
        results();
    end
endmodule
